// file: cal_trim_pkg.sv
package cal_trim_pkg;

  // register addresses on the serial register port
  localparam logic [3:0] ADDR_WEEKDAY = 4'h3;
  localparam logic [3:0] ADDR_DAY = 4'h4;
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR = 4'h6;
  localparam logic [3:0] ADDR_TRIM = 4'h7;
  localparam logic [3:0] ADDR_WALM_MIN = 4'h8;
  localparam logic [3:0] ADDR_WALM_HOUR = 4'h9;
  localparam logic [3:0] ADDR_WALM_MASK = 4'hA;

  // field widths
  localparam int DAY_W = 6;
  localparam int MONTH_W = 5;
  localparam int MIN_W = 7;
  localparam int HOUR_W = 6;
  localparam int WDAY_W = 3;
  localparam int MASK_W = 7;
  localparam int TRIM_MAG_W = 6;

  // month register layout
  localparam int CENTURY_BIT = 7;

  // trim register layout and reset value
  localparam int TRIM_SEL_BIT = 7;
  localparam int TRIM_DIR_BIT = 6;
  localparam logic [7:0] TRIM_RESET = 8'h00;

  // nominal second length in oscillator cycles
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] SEC_NOMINAL = 16'h8000;

  // bcd limits
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] DAY_31 = 8'h31;
  localparam logic [7:0] DAY_30 = 8'h30;
  localparam logic [7:0] DAY_29 = 8'h29;
  localparam logic [7:0] DAY_28 = 8'h28;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] MONTH_APR = 8'h04;
  localparam logic [7:0] MONTH_JUN = 8'h06;
  localparam logic [7:0] MONTH_SEP = 8'h09;
  localparam logic [7:0] MONTH_NOV = 8'h11;
  localparam logic [7:0] MONTH_DEC = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] YEAR_FIRST = 8'h00;
  localparam logic [5:0] HOUR_23 = 6'h23;
  localparam logic [5:0] HOUR_00 = 6'h00;
  localparam logic [5:0] HOUR_PM11 = 6'h31;
  localparam logic [5:0] HOUR_AM12 = 6'h12;
  localparam logic [6:0] SEC_00 = 7'h00;
  localparam logic [6:0] SEC_20 = 7'h20;
  localparam logic [6:0] SEC_40 = 7'h40;
  localparam logic [2:0] WDAY_FIRST = 3'h0;
  localparam logic [2:0] WDAY_LAST = 3'h6;

  // current time from the time counters
  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
  } time_now_t;

  // one register access from the serial port logic
  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic [7:0] wdata;
  } reg_req_t;

  // two-digit bcd increment, no wrap handling
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == BCD_NINE) begin
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction

endpackage

// file: pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // asynchronous pin
  input wire logic pin_i,
  // synchronised level and rising-edge strobe
  output logic level_o,
  output logic rise_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

  sync_state_t s_q, s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d = s_q;
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.s2;
  assign rise_o = s_q.s2 & ~s_q.s3;

endmodule

// file: trim_divider.sv
`timescale 1ns/100ps
module trim_divider
  import cal_trim_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // one strobe per oscillator cycle
  input wire logic osc_tick_i,
  // trim setting and its write strobe
  input wire logic [7:0] trim_i,
  input wire logic trim_wr_i,
  // seconds value from the time counters
  input wire logic [6:0] cur_sec_i,
  // one-cycle strobe at each second boundary
  output logic sec_tick_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] limit;
    logic load;
    logic trimmed;
    logic tick;
  } div_state_t;

  div_state_t s_q, s_d;
  logic [TRIM_MAG_W-1:0] mag;
  logic [TRIM_MAG_W-1:0] step;
  logic [CNT_W-1:0] adj;
  logic instant;
  logic active;
  logic [CNT_W-1:0] trim_len;
  logic [CNT_W-1:0] cnt_next;

  // correction size; both forms fit six bits for any active setting
  assign mag = trim_i[TRIM_MAG_W-1:0];
  assign step = trim_i[TRIM_DIR_BIT] ? TRIM_MAG_W'(~mag + 6'h01)
                                     : TRIM_MAG_W'(mag - 6'h01);
  assign adj = CNT_W'({step, 1'b0});
  assign active = |mag[TRIM_MAG_W-1:1];
  assign trim_len = trim_i[TRIM_DIR_BIT] ? CNT_W'(SEC_NOMINAL - adj) : CNT_W'(SEC_NOMINAL + adj);
  assign instant = trim_i[TRIM_SEL_BIT] ? (cur_sec_i == SEC_00)
    : (cur_sec_i == SEC_00 || cur_sec_i == SEC_20 || cur_sec_i == SEC_40);
  assign cnt_next = CNT_W'(s_q.cnt + 16'h0001);

  // length chosen one cycle after the boundary, once seconds have moved on
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.load) begin
      s_d.load = 1'b0;
      s_d.limit = SEC_NOMINAL;
      s_d.trimmed = 1'b0;
      if (instant && active && !trim_wr_i) begin
        s_d.limit = trim_len;
        s_d.trimmed = 1'b1;
      end
    end
    // a trim write inside a trimmed second drops that correction
    if (trim_wr_i && s_q.trimmed) begin
      s_d.limit = SEC_NOMINAL;
      s_d.trimmed = 1'b0;
    end
    if (osc_tick_i) begin
      if (cnt_next >= s_d.limit) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
        s_d.load = 1'b1;
      end else begin
        s_d.cnt = cnt_next;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '{cnt: '0, limit: SEC_NOMINAL, load: 1'b0, trimmed: 1'b0, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sec_tick_o = s_q.tick;

endmodule

// file: calendar_trim_weekly_alarm.sv
`timescale 1ns/100ps
// Behaviour
// - day of month counts 1..31 in long months, 1..30 in short ones
// - february ends at 29 in leap years, 28 otherwise
// - wrap of the day of month advances the month
// - month counts 1..12; wrap from 12 advances the year
// - year counts bcd 00..99; every year divisible by four is leap
// - century bit toggles when the year wraps from 99 to 00
// - month register: century bit 7, month bits 4..0, bits 6..5 read zero
// - trim register at 7h clears on power-up flag
// - trim at seconds 00, 20, 40, or only 00 when interval select set
// - direction 0 lengthens the second by (magnitude - 1) times 2
// - direction 1 shortens the second by (inverse magnitude + 1) times 2
// - magnitude bits 5..1 all zero means no correction
// - a nominal second is 32768 oscillator cycles
// - a trim write at the trim instant cancels that correction
// - 32 kHz clock output is never altered by the trim
// - weekly alarm minute at 8h, hour at 9h, day mask at Ah
// - alarm hour bit 5 is pm flag or tens-of-hours bit by mode
// - 12-hour midnight is bcd 12 and noon bcd 32
// - each mask bit enables one weekday code 000..110
// - empty day mask never signals the weekly alarm
// - weekday counts modulo seven on each day advance
// - weekly match flag sets only while enabled, reads 0 when disabled
// - day advances at hour wrap 23 to 00 or pm11 to am12
module calendar_trim_weekly_alarm
  import cal_trim_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // oscillator pin and buffered clock output
  input wire logic osc_32k_i,
  output logic clk_32k_o,
  // time counters
  input wire cal_trim_pkg::time_now_t time_now_i,
  output logic sec_tick_o,
  // register port from the serial interface logic
  input wire cal_trim_pkg::reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // power and alarm control
  input wire logic power_up_flag_i,
  input wire logic weekly_match_enable_i,
  input wire logic weekly_match_clear_i,
  output logic weekly_match_flag_o,
  // calendar state to the rest of the device
  output logic [2:0] weekday_code_o
);

  typedef struct packed {
    logic [DAY_W-1:0] day;
    logic century;
    logic [MONTH_W-1:0] month;
    logic [7:0] year;
    logic [WDAY_W-1:0] weekday;
    logic [7:0] trim;
    logic [MIN_W-1:0] alm_min;
    logic [HOUR_W-1:0] alm_hour;
    logic [MASK_W-1:0] alm_mask;
    logic [HOUR_W-1:0] hour_prev;
    logic match_prev;
    logic flag;
    logic [7:0] rdata;
  } cal_state_t;

  cal_state_t s_q, s_d;

  logic osc_level;
  logic osc_tick;
  logic trim_wr;
  logic day_adv;
  logic leap;
  logic [7:0] day_full;
  logic [7:0] month_full;
  logic [7:0] day_max;
  logic [MASK_W:0] mask_pad;
  logic match;

  // oscillator pin crosses into the system clock here
  pin_sync u_osc_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(osc_32k_i),
    .level_o(osc_level),
    .rise_o(osc_tick)
  );

  // clock output taps the synchronised pin, ahead of the divider
  assign clk_32k_o = osc_level;

  assign trim_wr = reg_req_i.wr && (reg_req_i.addr == ADDR_TRIM);

  // second divider carrying the time trim
  trim_divider u_divider (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .osc_tick_i(osc_tick),
    .trim_i(s_q.trim),
    .trim_wr_i(trim_wr),
    .cur_sec_i(time_now_i.sec),
    .sec_tick_o(sec_tick_o)
  );

  // hour rollover seen on the time counters starts a new day
  assign day_adv = (s_q.hour_prev == HOUR_23 && time_now_i.hour == HOUR_00)
    || (s_q.hour_prev == HOUR_PM11 && time_now_i.hour == HOUR_AM12);

  // bcd leap test: even tens with units 0,4,8 or odd tens with units 2,6
  assign leap = (!s_q.year[4] && s_q.year[1:0] == 2'b00)
    || (s_q.year[4] && s_q.year[1:0] == 2'b10);

  assign day_full = {2'b00, s_q.day};
  assign month_full = {3'b000, s_q.month};

  // last day of the current month
  always_comb begin
    day_max = DAY_31;
    if (month_full == MONTH_FEB) begin
      day_max = leap ? DAY_29 : DAY_28;
    end else if (month_full == MONTH_APR || month_full == MONTH_JUN
                 || month_full == MONTH_SEP || month_full == MONTH_NOV) begin
      day_max = DAY_30;
    end
  end

  // pad the mask so code 111 indexes a zero bit
  assign mask_pad = {1'b0, s_q.alm_mask};

  // minute and hour compared raw, so 12 and 32 encodings match as stored
  assign match = (s_q.alm_min == time_now_i.min)
    && (s_q.alm_hour == time_now_i.hour)
    && mask_pad[s_q.weekday];

  always_comb begin
    s_d = s_q;
    s_d.hour_prev = time_now_i.hour;
    s_d.match_prev = match;

    // calendar carry chain
    if (day_adv) begin
      if (s_q.weekday >= WDAY_LAST) begin
        s_d.weekday = WDAY_FIRST;
      end else begin
        s_d.weekday = WDAY_W'(s_q.weekday + 3'h1);
      end
      // >= keeps an impossible written day from running away
      if (day_full >= day_max) begin
        s_d.day = DAY_W'(BCD_ONE);
        if (month_full >= MONTH_DEC) begin
          s_d.month = MONTH_W'(BCD_ONE);
          if (s_q.year >= YEAR_LAST) begin
            s_d.year = YEAR_FIRST;
            s_d.century = ~s_q.century;
          end else begin
            s_d.year = bcd_inc(s_q.year);
          end
        end else begin
          s_d.month = MONTH_W'(bcd_inc(month_full));
        end
      end else begin
        s_d.day = DAY_W'(bcd_inc(day_full));
      end
    end

    // host writes override counting in the same cycle
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        ADDR_WEEKDAY: s_d.weekday = reg_req_i.wdata[WDAY_W-1:0];
        ADDR_DAY: s_d.day = reg_req_i.wdata[DAY_W-1:0];
        ADDR_MONTH: begin
          s_d.century = reg_req_i.wdata[CENTURY_BIT];
          s_d.month = reg_req_i.wdata[MONTH_W-1:0];
        end
        ADDR_YEAR: s_d.year = reg_req_i.wdata;
        ADDR_TRIM: s_d.trim = reg_req_i.wdata;
        ADDR_WALM_MIN: s_d.alm_min = reg_req_i.wdata[MIN_W-1:0];
        ADDR_WALM_HOUR: s_d.alm_hour = reg_req_i.wdata[HOUR_W-1:0];
        ADDR_WALM_MASK: s_d.alm_mask = reg_req_i.wdata[MASK_W-1:0];
        default: ;
      endcase
    end

    // power-up from zero volts clears the trim, over any write
    if (power_up_flag_i) begin
      s_d.trim = TRIM_RESET;
    end

    // alarm flag: the new match wins over a clear in the same cycle
    if (!weekly_match_enable_i) begin
      s_d.flag = 1'b0;
    end else if (match && !s_q.match_prev) begin
      s_d.flag = 1'b1;
    end else if (weekly_match_clear_i) begin
      s_d.flag = 1'b0;
    end

    // read data registered; unused high bits and other addresses read zero
    unique case (reg_req_i.addr)
      ADDR_WEEKDAY: s_d.rdata = {5'h00, s_q.weekday};
      ADDR_DAY: s_d.rdata = {2'b00, s_q.day};
      ADDR_MONTH: s_d.rdata = {s_q.century, 2'b00, s_q.month};
      ADDR_YEAR: s_d.rdata = s_q.year;
      ADDR_TRIM: s_d.rdata = s_q.trim;
      ADDR_WALM_MIN: s_d.rdata = {1'b0, s_q.alm_min};
      ADDR_WALM_HOUR: s_d.rdata = {2'b00, s_q.alm_hour};
      ADDR_WALM_MASK: s_d.rdata = {1'b0, s_q.alm_mask};
      default: s_d.rdata = 8'h00;
    endcase
  end

  // calendar resets to a real date so the carry chain starts sane
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.day <= DAY_W'(BCD_ONE);
      s_q.month <= MONTH_W'(BCD_ONE);
      s_q.trim <= TRIM_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // flag shown only while enabled, with no lag on disable
  assign weekly_match_flag_o = s_q.flag & weekly_match_enable_i;
  assign reg_rdata_o = s_q.rdata;
  assign weekday_code_o = s_q.weekday;

endmodule

// file: cal_chk.sv
`timescale 1ns/100ps
module cal_chk (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic osc_32k_i,
  input wire logic clk_32k_o,
  input wire cal_trim_pkg::time_now_t time_now_i,
  input wire logic sec_tick_o,
  input wire cal_trim_pkg::reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic power_up_flag_i,
  input wire logic weekly_match_enable_i,
  input wire logic weekly_match_clear_i,
  input wire logic weekly_match_flag_o,
  input wire logic [2:0] weekday_code_o
);
  import cal_trim_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // previous hour, to spot the two kinds of day wrap
  logic [5:0] hour_q;
  logic wrap24_c;
  logic wrap12_c;
  always_ff @(posedge sys_clk_i) begin
    hour_q <= time_now_i.hour;
  end
  assign wrap24_c = (hour_q == HOUR_23) && (time_now_i.hour == HOUR_00);
  assign wrap12_c = (hour_q == HOUR_PM11) && (time_now_i.hour == HOUR_AM12);
  sec_pulse_a: assert property (sec_tick_o |=> !sec_tick_o)
    else $error("second tick wider than one cycle");
  clk_copy_a: assert property (
    $past(rst_n_i) && $past(rst_n_i, 2) |-> clk_32k_o == $past(osc_32k_i, 2))
    else $error("clock output not a plain copy");
  flag_off_a: assert property (!weekly_match_enable_i |-> !weekly_match_flag_o)
    else $error("flag seen while disabled");
  wday_step24_a: assert property (
    wrap24_c && !reg_req_i.wr && $past(rst_n_i) |=> weekday_code_o ==
      (($past(weekday_code_o) == WDAY_LAST) ? WDAY_FIRST : $past(weekday_code_o) + 3'h1))
    else $error("weekday missed 24h wrap");
  wday_step12_a: assert property (
    wrap12_c && !reg_req_i.wr && $past(rst_n_i) |=> weekday_code_o ==
      (($past(weekday_code_o) == WDAY_LAST) ? WDAY_FIRST : $past(weekday_code_o) + 3'h1))
    else $error("weekday missed 12h wrap");
  wday_hold_a: assert property (
    !wrap24_c && !wrap12_c && !reg_req_i.wr |=> $stable(weekday_code_o))
    else $error("weekday moved without cause");
  unmap_read_a: assert property (
    (reg_req_i.addr < ADDR_WEEKDAY) || (reg_req_i.addr > ADDR_WALM_MASK)
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  month_bits_a: assert property (reg_req_i.addr == ADDR_MONTH |=> reg_rdata_o[6:5] == 2'b00)
    else $error("month spare bits set");
  alarm_hour_a: assert property (
    reg_req_i.addr == ADDR_WALM_HOUR |=> reg_rdata_o[7:6] == 2'b00)
    else $error("alarm hour spare bits set");
  trim_clear_a: assert property (
    power_up_flag_i && !reg_req_i.wr ##1 reg_req_i.addr == ADDR_TRIM && !reg_req_i.wr
    |=> reg_rdata_o == TRIM_RESET)
    else $error("trim not cleared by power-up flag");
endmodule

// file: host_model.sv
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic sys_clk_i,
  // register port
  input wire logic [7:0] reg_rdata_i,
  output cal_trim_pkg::reg_req_t reg_req_o
);
  import cal_trim_pkg::*;
  initial reg_req_o = '0;
  // one byte write; callers also send bytes that are not real dates or times, such as FF
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_req_o <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge sys_clk_i);
    reg_req_o.wr <= 1'b0;
    reg_req_o.wdata <= ~d; // released data must not look valid
  endtask
  // address held until the registered answer has settled
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_req_o.addr <= a;
    // second edge after the address: data launched at the first edge stands here
    repeat (2) @(posedge sys_clk_i);
    d = reg_rdata_i;
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  import cal_trim_pkg::*;
  logic sys_clk, rst_n, osc, pwr_up, en, clr, flag, sec_tick, clk_out;
  logic [7:0] rdata;
  logic [2:0] wday;
  time_now_t now;
  reg_req_t req;
  int error_cnt = 0;
  int cmp_count = 0;
  int tick_cnt = 0;
  calendar_trim_weekly_alarm calendar_trim_weekly_alarm_inst (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .osc_32k_i(osc), .clk_32k_o(clk_out),
    .time_now_i(now), .sec_tick_o(sec_tick), .reg_req_i(req), .reg_rdata_o(rdata),
    .power_up_flag_i(pwr_up), .weekly_match_enable_i(en), .weekly_match_clear_i(clr),
    .weekly_match_flag_o(flag), .weekday_code_o(wday));
  host_model host_model_inst (.sys_clk_i(sys_clk), .reg_rdata_i(rdata), .reg_req_o(req));
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // count second boundaries
  always @(posedge sys_clk) begin
    if (sec_tick === 1'b1) tick_cnt++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    host_model_inst.rd(a, v);
    chk(v, exp, what);
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_reset;
    rchk(ADDR_TRIM, TRIM_RESET, "trim at reset");
  endtask
  // addr, write, expected read; spare high bits are dropped
  task automatic t_regs;
    logic [19:0] tab [8];
    tab = '{20'h8FF7F, 20'h9FF3F, 20'hAFF7F, 20'h93232, 20'h5E181, 20'hB5500,
      20'h7C1C1, 20'h74141};
    foreach (tab[i]) begin
      host_model_inst.wr(tab[i][19:16], tab[i][15:8]);
      rchk(tab[i][19:16], tab[i][7:0], "readback");
    end
    @(posedge sys_clk);
    pwr_up <= 1'b1;
    @(posedge sys_clk);
    pwr_up <= 1'b0;
    rchk(ADDR_TRIM, TRIM_RESET, "trim after power-up");
  endtask
  // day, month, year, hour from, hour to, then expected day, month, year, weekday in/out
  task automatic t_cal;
    logic [79:0] tab [10];
    logic [79:0] c;
    tab = '{80'h31012323000102230600, 80'h30042323000105230203,
      80'h30012323003101230203, 80'h28022323000103230203, 80'h28022423002902240203,
      80'h28020031122902000203, 80'h31129923000181000203, 80'h31929923000101000203,
      80'h10032322231003230202, 80'h30112331120112230506};
    foreach (tab[i]) begin
      c = tab[i];
      @(posedge sys_clk);
      now.hour <= c[53:48];
      host_model_inst.wr(ADDR_WEEKDAY, c[15:8]);
      host_model_inst.wr(ADDR_DAY, c[79:72]);
      host_model_inst.wr(ADDR_MONTH, c[71:64]);
      host_model_inst.wr(ADDR_YEAR, c[63:56]);
      @(posedge sys_clk);
      now.hour <= c[45:40];
      rchk(ADDR_DAY, c[39:32], "day");
      rchk(ADDR_MONTH, c[31:24], "month");
      rchk(ADDR_YEAR, c[23:16], "year");
      rchk(ADDR_WEEKDAY, c[7:0], "weekday");
    end
  endtask
  // mask, weekday, hour, enable and expected flag; alarm set to 13:30
  task automatic t_alarm;
    logic [31:0] tab [6];
    tab = '{32'h08031311, 32'hF7031310, 32'h00031310, 32'h7F031410, 32'h7F061300,
      32'h40061311};
    host_model_inst.wr(ADDR_WALM_MIN, 8'h30);
    host_model_inst.wr(ADDR_WALM_HOUR, 8'h13);
    foreach (tab[i]) begin
      host_model_inst.wr(ADDR_WALM_MASK, tab[i][31:24]);
      host_model_inst.wr(ADDR_WEEKDAY, tab[i][23:16]);
      @(posedge sys_clk);
      en <= tab[i][4];
      now.hour <= tab[i][13:8];
      now.min <= 7'h30;
      repeat (3) @(posedge sys_clk);
      #1 chk({7'h00, flag}, {7'h00, tab[i][0]}, "weekly flag");
      @(posedge sys_clk);
      clr <= 1'b1;
      now.min <= 7'h00;
      @(posedge sys_clk);
      clr <= 1'b0;
    end
  endtask
  // one untrimmed second needs exactly 32768 oscillator rises
  task automatic t_second;
    int c0;
    c0 = tick_cnt;
    repeat (32767) begin
      @(posedge sys_clk);
      osc <= 1'b1;
      @(posedge sys_clk);
      osc <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    #1 chk(8'(tick_cnt - c0), 8'h00, "second too short");
    @(posedge sys_clk);
    osc <= 1'b1;
    @(posedge sys_clk);
    osc <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 chk(8'(tick_cnt - c0), 8'h01, "second length");
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    osc = 1'b0;
    now = '0;
    pwr_up = 1'b0;
    en = 1'b0;
    clr = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_cal();
    t_alarm();
    t_second();
    end_sim();
  end
  // watchdog a little beyond the long second, well under the cycle budget
  initial begin
    #300000;
    error_cnt++;
    end_sim();
  end
endmodule
bind calendar_trim_weekly_alarm cal_chk cal_chk_inst (.sys_clk_i, .rst_n_i, .osc_32k_i,
  .clk_32k_o, .time_now_i, .sec_tick_o, .reg_req_i, .reg_rdata_o, .power_up_flag_i,
  .weekly_match_enable_i, .weekly_match_clear_i, .weekly_match_flag_o, .weekday_code_o);
